// *** include/drc_pkg.sv ***
package drc_pkg;
   // ----------------------------------------------------------------
   // register map: printed offsets are word indices, byte address = 4*index
   // ----------------------------------------------------------------
   localparam int ADDR_W = 18;                         // byte address width
   localparam int DATA_W = 32;                         // bus data width
   localparam int REG_W = 16;                          // register width
   localparam logic [15:0] IDX_SLEEP_REQ = 16'hF400;   // core_sleep_request
   localparam logic [15:0] IDX_STROBE_SEL = 16'hF401;  // frame_strobe_select
   localparam logic [15:0] IDX_RUN_TRIG = 16'hF402;    // core_run_trigger
   localparam logic [15:0] IDX_ENTRY = 16'hF404;       // program entry point
   localparam logic [15:0] IDX_STATUS = 16'hF410;      // run state readback
   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_SLEEP_REQ = 16'h0000;   // running
   localparam logic [15:0] RST_STROBE_SEL = 16'h0002;  // x1 base rate
   localparam logic [15:0] RST_RUN_TRIG = 16'h0000;    // not triggered
   localparam logic [15:0] RST_ENTRY = 16'h0000;       // entry address
   localparam int SLEEP_BIT = 0;                       // sleep request bit
   localparam int RUN_BIT = 0;                         // run trigger bit
   localparam int SEL_W = 5;                           // selector field width
   localparam int STAT_EDGE_BIT = 2;                   // block boundary flag
   // ----------------------------------------------------------------
   // frame strobe selector codes
   // ----------------------------------------------------------------
   localparam logic [4:0] SEL_CG1_FIRST = 5'h00;       // clock gen 1, /4
   localparam logic [4:0] SEL_CG2_FIRST = 5'h05;       // clock gen 2, /6
   localparam logic [4:0] SEL_SIN_FIRST = 5'h08;       // serial input 0
   localparam logic [4:0] SEL_SOUT_FIRST = 5'h0C;      // serial output 0
   localparam logic [4:0] SEL_SPDIF = 5'h10;           // spdif receiver
   localparam int NUM_SRC = 17;                        // defined sources
   // ----------------------------------------------------------------
   // bus responses and core states
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;            // accepted
   localparam logic [1:0] RESP_SLVERR = 2'h2;          // unmapped address
   typedef enum logic [1:0] {
      DRC_STOP = 2'h0,                                 // never launched
      DRC_WAIT = 2'h1,                                 // awaiting frame strobe
      DRC_EXEC = 2'h3,                                 // running one sample
      DRC_SLEEP = 2'h2                                 // sleeping, irqs masked
   } drc_state_t;
endpackage : drc_pkg

// *** hw/drc_core_ctrl.sv ***
`timescale 1ns/10ps
module drc_core_ctrl
   import drc_pkg::*;
(
   input wire logic aclk,                      // 20 MHz system clock
   input wire logic aresetn,                   // synchronous reset, low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid,             // write address valid
   output logic s_axi_awready,                 // write address ready
   input wire logic [DATA_W-1:0] s_axi_wdata,  // write data
   input wire logic [3:0] s_axi_wstrb,         // write byte enables
   input wire logic s_axi_wvalid,              // write data valid
   output logic s_axi_wready,                  // write data ready
   output logic [1:0] s_axi_bresp,             // write response
   output logic s_axi_bvalid,                  // write response valid
   input wire logic s_axi_bready,              // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid,             // read address valid
   output logic s_axi_arready,                 // read address ready
   output logic [DATA_W-1:0] s_axi_rdata,      // read data
   output logic [1:0] s_axi_rresp,             // read response
   output logic s_axi_rvalid,                  // read data valid
   input wire logic s_axi_rready,              // read data ready
   input wire logic [4:0] cg1_strobe,          // clock gen 1: /4 /2 x1 x2 x4
   input wire logic [2:0] cg2_strobe,          // clock gen 2: /6 /3 x2/3
   input wire logic [3:0] sin_frame,           // serial input port frames
   input wire logic [3:0] sout_frame,          // serial output port frames
   input wire logic spdif_frame,               // spdif recovered frame
   input wire logic block_mode,                // program uses block processing
   input wire logic block_end,                 // current sample closes a block
   input wire logic instr_last,                // fetched word ends the pass
   output logic frame_start,                   // frame start pulse to core
   output logic [15:0] fetch_addr,             // program memory address
   output logic fetch_en,                      // program memory read enable
   output logic core_irq_en,                   // core interrupts allowed
   output logic core_running                   // core launched and awake
);
   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      return v;
   endfunction : lane_merge

   // true for every word index that holds a register
   function automatic logic is_mapped(input logic [15:0] idx);
      return (idx == IDX_SLEEP_REQ) || (idx == IDX_STROBE_SEL) ||
             (idx == IDX_RUN_TRIG) || (idx == IDX_ENTRY) || (idx == IDX_STATUS);
   endfunction : is_mapped

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic aw_held_r;                 // write address captured
   logic [15:0] aw_idx_r;           // captured word index
   logic w_held_r;                  // write data captured
   logic [31:0] wdata_r;            // captured write data
   logic [3:0] wstrb_r;             // captured byte enables
   logic bvalid_r;                  // write response pending
   logic [1:0] bresp_r;             // write response code
   logic rvalid_r;                  // read data pending
   logic [31:0] rdata_r;            // read data word
   logic [1:0] rresp_r;             // read response code
   logic wr_fire;                   // register write this cycle
   logic [15:0] sleep_req_r;        // core_sleep_request
   logic [15:0] strobe_sel_r;       // frame_strobe_select
   logic [15:0] run_trig_r;         // core_run_trigger
   logic [15:0] entry_r;            // program entry point
   logic [15:0] run_trig_nxt;       // run trigger after this write
   logic run_rise;                  // run bit 0 to 1 this cycle
   logic [NUM_SRC-1:0] src_vec;     // all strobe sources in code order
   logic sel_strobe;                // selected frame strobe
   logic sleep_now;                 // sleep requested
   logic edge_ok;                   // at a block boundary
   logic go_ok;                     // a new pass may start
   drc_state_t state_r;             // core run state
   logic [15:0] pc_r;               // program counter
   logic blk_edge_r;                // last finished sample closed a block
   logic [15:0] status_w;           // status readback

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

   // address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_idx_r <= 16'h0000;
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[17:2];
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   assign run_trig_nxt = lane_merge(run_trig_r, wdata_r, wstrb_r);
   // only a 0 to 1 write launches, a 1 to 0 write is stored only
   assign run_rise = wr_fire && (aw_idx_r == IDX_RUN_TRIG) &&
                     run_trig_nxt[RUN_BIT] && !run_trig_r[RUN_BIT];

   // register storage, reserved bits held as written
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_req_r <= RST_SLEEP_REQ;
         strobe_sel_r <= RST_STROBE_SEL;
         run_trig_r <= RST_RUN_TRIG;
         entry_r <= RST_ENTRY;
      end else if (wr_fire) begin
         case (aw_idx_r)
            IDX_SLEEP_REQ: begin
               sleep_req_r <= lane_merge(sleep_req_r, wdata_r, wstrb_r);
            end
            IDX_STROBE_SEL: begin
               strobe_sel_r <= lane_merge(strobe_sel_r, wdata_r, wstrb_r);
            end
            IDX_RUN_TRIG: begin
               run_trig_r <= run_trig_nxt;
            end
            IDX_ENTRY: begin
               entry_r <= lane_merge(entry_r, wdata_r, wstrb_r);
            end
            default: begin
               // unmapped or read-only: nothing stored
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign status_w = {13'h0000, blk_edge_r, state_r};

   // read data registered one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r <= is_mapped(s_axi_araddr[17:2]) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr[17:2])
            IDX_SLEEP_REQ: rdata_r <= {16'h0000, sleep_req_r};
            IDX_STROBE_SEL: rdata_r <= {16'h0000, strobe_sel_r};
            IDX_RUN_TRIG: rdata_r <= {16'h0000, run_trig_r};
            IDX_ENTRY: rdata_r <= {16'h0000, entry_r};
            IDX_STATUS: rdata_r <= {16'h0000, status_w};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // frame strobe selection
   // ----------------------------------------------------------------
   // sources packed so that the selector code is the bit index
   assign src_vec[4:0] = cg1_strobe;
   assign src_vec[7:5] = cg2_strobe;
   assign src_vec[11:8] = sin_frame;
   assign src_vec[15:12] = sout_frame;
   assign src_vec[16] = spdif_frame;

   // codes past the last source give no strobe at all
   always_comb begin
      if (strobe_sel_r[SEL_W-1:0] <= SEL_SPDIF) begin
         sel_strobe = src_vec[strobe_sel_r[SEL_W-1:0]];
      end else begin
         sel_strobe = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // core run state and program counter
   // ----------------------------------------------------------------
   assign sleep_now = sleep_req_r[SLEEP_BIT];
   // a block flow may only stop on a block boundary
   assign edge_ok = !block_mode || block_end;
   // an open block keeps taking passes under a sleep request, else it hangs
   assign go_ok = !sleep_now || (block_mode && !blk_edge_r);

   // stop -> wait -> exec -> wait ... with sleep taken between passes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= DRC_STOP;
      end else begin
         case (state_r)
            DRC_STOP: begin
               if (run_rise) begin
                  state_r <= DRC_WAIT;
               end
            end
            DRC_WAIT: begin
               if (sleep_now && (!block_mode || blk_edge_r)) begin
                  state_r <= DRC_SLEEP;
               end else if (sel_strobe && go_ok) begin
                  state_r <= DRC_EXEC;
               end
            end
            DRC_EXEC: begin
               // the pass in progress always runs to its last word
               if (instr_last) begin
                  state_r <= (sleep_now && edge_ok) ? DRC_SLEEP : DRC_WAIT;
               end
            end
            DRC_SLEEP: begin
               if (!sleep_now) begin
                  state_r <= DRC_WAIT;
               end
            end
            default: begin
               state_r <= DRC_STOP;
            end
         endcase
      end
   end

   // block boundary tracking for sleep in block flows
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blk_edge_r <= 1'b1;
      end else if (state_r == DRC_EXEC && instr_last) begin
         blk_edge_r <= block_end;
      end
   end

   // pc loads the entry point, then steps one word per cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_r <= RST_ENTRY;
      end else if (run_rise && state_r == DRC_STOP) begin
         pc_r <= entry_r;
      end else if (state_r == DRC_WAIT && sel_strobe && go_ok) begin
         pc_r <= entry_r;
      end else if (state_r == DRC_EXEC && !instr_last) begin
         pc_r <= pc_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the core
   // ----------------------------------------------------------------
   assign fetch_addr = pc_r;
   assign fetch_en = (state_r == DRC_EXEC);
   // no interrupts and so no sample movement while asleep or asking to
   assign core_irq_en = (state_r != DRC_STOP) && (state_r != DRC_SLEEP) &&
                        !sleep_now;
   assign core_running = (state_r == DRC_WAIT) || (state_r == DRC_EXEC);
   assign frame_start = (state_r == DRC_WAIT) && sel_strobe && go_ok;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_values: assert property ($rose(aresetn) |->
      sleep_req_r == RST_SLEEP_REQ && strobe_sel_r == RST_STROBE_SEL)
      else $error("control registers wrong after reset");
   a_launch_entry: assert property (state_r == DRC_STOP && run_rise |=>
      state_r == DRC_WAIT && pc_r == $past(entry_r))
      else $error("launch did not load entry point");
   a_fall_ignored: assert property (state_r == DRC_STOP && !run_rise |=>
      state_r == DRC_STOP)
      else $error("core left stop without a rising run bit");
   a_sleep_masks: assert property (state_r == DRC_SLEEP |->
      !core_irq_en && !frame_start && !fetch_en)
      else $error("interrupts open while sleeping");
   a_pass_finishes: assert property (state_r == DRC_EXEC && !instr_last |=>
      state_r == DRC_EXEC)
      else $error("pass cut short before its last word");
   a_sleep_after_pass: assert property (state_r == DRC_EXEC && instr_last &&
      sleep_now && edge_ok |=> state_r == DRC_SLEEP)
      else $error("no sleep after finished pass");
   a_pc_steps: assert property (state_r == DRC_EXEC && !instr_last |=>
      pc_r == $past(pc_r) + 16'h0001)
      else $error("program counter did not step");
   a_no_strobe_high: assert property (strobe_sel_r[SEL_W-1:0] > SEL_SPDIF |->
      !frame_start)
      else $error("strobe from undefined selector code");
   a_select_base: assert property (state_r == DRC_WAIT && !sleep_now &&
      strobe_sel_r[SEL_W-1:0] == SEL_CG2_FIRST && cg2_strobe[0] |->
      frame_start ##1 state_r == DRC_EXEC)
      else $error("selected strobe did not start a frame");
   a_spdif_pick: assert property (strobe_sel_r[SEL_W-1:0] == SEL_SPDIF &&
      !spdif_frame |-> !frame_start)
      else $error("frame started without spdif strobe");
endmodule : drc_core_ctrl

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb
   import drc_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   typedef struct {logic [4:0] sel; logic [16:0] src; logic exp;} drc_row_t;
   logic aclk, aresetn;                          // clock and reset
   logic [ADDR_W-1:0] awaddr, araddr;            // bus addresses
   logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
   logic awready, wready, bvalid, arready, rvalid; // slave handshakes
   logic [DATA_W-1:0] wdata, rdata;              // bus data
   logic [1:0] bresp, rresp;                     // bus responses
   logic [16:0] src;                             // strobes, bit n = selector code n
   logic block_mode, block_end, instr_last;      // core pass inputs
   logic frame_start, fetch_en, core_irq_en, core_running;
   logic [15:0] fetch_addr;                      // program address
   int n_mismatch = 0;                           // failed checks
   int n_tests = 0;                              // checks made
   drc_row_t rows[$];                            // selector table
   logic [31:0] d;                               // read data
   logic [1:0] rsp;                              // read response
   logic fs;                                     // sampled frame start

   drc_core_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cg1_strobe(src[4:0]), .cg2_strobe(src[7:5]),
      .sin_frame(src[11:8]), .sout_frame(src[15:12]), .spdif_frame(src[16]),
      .block_mode(block_mode), .block_end(block_end), .instr_last(instr_last),
      .frame_start(frame_start), .fetch_addr(fetch_addr), .fetch_en(fetch_en),
      .core_irq_en(core_irq_en), .core_running(core_running));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // bus write: address and data offered together, each released when taken
   task automatic wok(input logic [15:0] idx, input logic [31:0] v, input logic [1:0] er);
      logic a, w, ta, tw, bh;
      a = 1'b0;
      w = 1'b0;
      bh = 1'b0;
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(negedge aclk);
         ta = !a && awready;
         tw = !w && wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         a = a | ta;
         w = w | tw;
      end
      while (!bh) begin
         @(negedge aclk);
         bh = bvalid;
         chk(32'(bh ? bresp : er), 32'(er));
         @(posedge aclk);
      end
      bready <= 1'b0;
   endtask : wok

   // bus read: rready held until the answer is sampled
   task automatic rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] r);
      logic t;
      t = 1'b0;
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!t) begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      t = 1'b0;
      while (!t) begin
         @(negedge aclk);
         t = rvalid;
         v = rdata;
         r = rresp;
         @(posedge aclk);
      end
      rready <= 1'b0;
   endtask : rd

   // one-cycle strobe pattern, frame start sampled in that cycle
   task automatic pulse(input logic [16:0] v, output logic f);
      @(posedge aclk);
      src <= v; // strobes share aclk, no rate converter needed
      @(negedge aclk);
      f = frame_start;
      @(posedge aclk);
      src <= '0;
   endtask : pulse

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // whole run is a few hundred cycles; 20000 cycles means a hang
   initial begin
      #1000000;
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, block_mode, block_end} = '0;
      {awaddr, araddr, wdata, src} = '0;
      instr_last = 1'b1;
      for (int c = 0; c < 32; c++) begin
         if (c < NUM_SRC) begin
            rows.push_back('{5'(c), 17'h1 << c, 1'b1});
            rows.push_back('{5'(c), ~(17'h1 << c), 1'b0});
         end else rows.push_back('{5'(c), 17'h1FFFF, 1'b0});
      end
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({fetch_en, core_irq_en, core_running}, 32'h0);
      rd(IDX_SLEEP_REQ, d, rsp);
      chk(d, 32'h0000);
      rd(IDX_STROBE_SEL, d, rsp);
      chk(d, 32'h0002);
      rd(IDX_RUN_TRIG, d, rsp);
      chk(d, 32'h0000);
      rd(16'hF4FF, d, rsp);
      chk({d[29:0], rsp}, {30'h0, RESP_SLVERR});
      wok(16'hF4FF, 32'h0001, RESP_SLVERR);
      pulse(17'h00004, fs);
      chk(32'(fs), 32'h0);
      $display("test reset done");
      // launch from the entry register
      wok(IDX_ENTRY, 32'h0100, RESP_OKAY);
      wok(IDX_RUN_TRIG, 32'h0001, RESP_OKAY);
      @(negedge aclk);
      chk({core_running, core_irq_en}, 32'h3);
      // every selector code, right strobe and all wrong strobes
      foreach (rows[i]) begin
         wok(IDX_STROBE_SEL, {27'h0, rows[i].sel}, RESP_OKAY);
         pulse(rows[i].src, fs);
         chk(32'(fs), 32'(rows[i].exp));
         @(negedge aclk);
         chk(32'(fetch_en), 32'(rows[i].exp));
      end
      $display("test selector done");
      // program counter steps from the entry point
      @(posedge aclk);
      instr_last <= 1'b0;
      wok(IDX_STROBE_SEL, 32'h0002, RESP_OKAY);
      pulse(17'h00004, fs);
      for (int k = 0; k < 4; k++) begin
         @(negedge aclk);
         chk({fetch_en, fetch_addr}, {1'b1, 16'(16'h0100 + k)});
      end
      @(posedge aclk);
      instr_last <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      chk(32'(fetch_en), 32'h0);
      // falling run bit leaves the core running
      wok(IDX_RUN_TRIG, 32'h0000, RESP_OKAY);
      @(negedge aclk);
      chk(32'(core_running), 32'h1);
      pulse(17'h00004, fs);
      chk(32'(fs), 32'h1);
      $display("test run done");
      // sleep in block flow: waits for the pass that closes a block
      @(posedge aclk);
      {instr_last, block_mode, block_end} <= 3'b010;
      pulse(17'h00004, fs);
      wok(IDX_SLEEP_REQ, 32'h0001, RESP_OKAY);
      @(negedge aclk);
      chk({fetch_en, core_irq_en}, 32'h2);
      @(posedge aclk);
      instr_last <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      chk({fetch_en, core_running}, 32'h1);
      rd(IDX_STATUS, d, rsp);
      chk(32'(d[2:0]), 32'h1);
      pulse(17'h00004, fs);
      chk(32'(fs), 32'h1);
      wok(IDX_SLEEP_REQ, 32'h0000, RESP_OKAY);
      @(posedge aclk);
      {instr_last, block_end} <= 2'b01;
      pulse(17'h00004, fs);
      wok(IDX_SLEEP_REQ, 32'h0001, RESP_OKAY);
      @(posedge aclk);
      instr_last <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      chk({fetch_en, core_running, core_irq_en}, 32'h0);
      rd(IDX_STATUS, d, rsp);
      chk(32'(d[2:0]), 32'h6);
      pulse(17'h1FFFF, fs);
      chk(32'(fs), 32'h0);
      rd(IDX_SLEEP_REQ, d, rsp);
      chk(d, 32'h0001);
      wok(IDX_SLEEP_REQ, 32'h0000, RESP_OKAY);
      @(negedge aclk);
      chk({core_running, core_irq_en}, 32'h3);
      // sample flow: sleep taken at once from wait
      @(posedge aclk);
      block_mode <= 1'b0;
      wok(IDX_SLEEP_REQ, 32'h0001, RESP_OKAY);
      @(negedge aclk);
      chk({core_running, core_irq_en}, 32'h0);
      $display("test sleep done");
      summarize();
   end
endmodule : tb
